// *** include/iicl_pkg.sv ***
// Constants, register map and helpers for the two-wire line and mode control block.
// Assumes a 40 MHz system clock and an APB master with 12-bit byte addresses.
package iicl_pkg;
	// System clock period and the half period of one transfer clock.
	localparam int unsigned CLK_SYS_NS   = 25;
	localparam int unsigned HALF_BIT_NS  = 2500;
	localparam int unsigned HALF_BIT_CYC = (HALF_BIT_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_LINE_CONTROL  = 10'h0B9;
	localparam logic [9:0] IDX_TRANSFER_MODE = 10'h0BA;
	localparam logic [9:0] IDX_CORE_CONTROL  = 10'h0C0;
	localparam logic [9:0] IDX_CORE_DATA     = 10'h0C1;
	// Reset values.
	localparam logic [7:0] LC_RESET = 8'h7D;
	localparam logic [7:0] TM_RESET = 8'h18;
	// Line control fields.
	localparam int LC_BUSY  = 7;
	localparam int LC_SCP   = 6;
	localparam int LC_DATA_OUT_CONTROL  = 5;
	localparam int LC_DATA_OUT_WRITE_PROTECT = 4;
	localparam int LC_CLOCK_LINE_MONITOR  = 3;
	// Transfer mode fields.
	localparam int TM_MLS   = 7;
	localparam int TM_WAIT  = 6;
	localparam int TM_RSV   = 5;
	localparam int TM_COUNTER_WRITE_PROTECT  = 3;
	// Core control fields.
	localparam int CC_MASTER = 0;
	localparam int CC_CSYNC  = 1;
	localparam int CC_ACK    = 6;
	localparam int CC_ACTIVE = 7;
	// Wait insertion lasts two transfer clocks, that is four half periods.
	localparam logic [1:0] WAIT_LAST_HALF = 2'h3;
	localparam logic [2:0] BC_ZERO        = 3'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_STOP,
		ST_BIT_LO,
		ST_BIT_HI,
		ST_WAIT
	} iicl_state_type;

	// Number of bits that a counter code stands for.
	function automatic logic [3:0] iicl_bc_len(input logic [2:0] code, input logic csync);
		if (csync) begin
			iicl_bc_len = (code == BC_ZERO) ? 4'h8 : {1'b0, code};
		end else begin
			iicl_bc_len = (code == BC_ZERO) ? 4'h9 : 4'({1'b0, code} + 4'h1);
		end
	endfunction : iicl_bc_len

	// Counter code that shows a number of remaining bits.
	function automatic logic [2:0] iicl_bc_code(input logic [3:0] rem, input logic csync);
		if (csync) begin
			iicl_bc_code = (rem == 4'h8) ? BC_ZERO : rem[2:0];
		end else begin
			iicl_bc_code = (rem == 4'h9) ? BC_ZERO : 3'(rem[2:0] - 3'h1);
		end
	endfunction : iicl_bc_code
endpackage : iicl_pkg

// *** design/iicl_line_ctrl.sv ***
// Line monitor, start and stop generation, bit counter and shifter of a two-wire interface.
// Assumes an APB master on CLK_SYS and open-drain pins resolved outside with pull-ups.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module iicl_line_ctrl
	import iicl_pkg::*;
#(
	parameter int HALF_CYC = HALF_BIT_CYC
) (
	// Clock and reset.
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	// Clock line.
	input  wire logic        SCL_I,
	output var  logic        SCL_O,
	output var  logic        SCL_OE,
	// Data line.
	input  wire logic        SDA_I,
	output var  logic        SDA_O,
	output var  logic        SDA_OE
);
	if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_chk
		$error("HALF_CYC out of range");
	end

	// Pin synchronisers; the edge detectors compare the second stage with the third.
	logic scl_s1_ff, scl_s2_ff, scl_d3_ff;
	logic sda_s1_ff, sda_s2_ff, sda_d3_ff;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_d3_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_d3_ff <= 1'b1;
		end else begin
			scl_s1_ff <= SCL_I;
			scl_s2_ff <= scl_s1_ff;
			scl_d3_ff <= scl_s2_ff;
			sda_s1_ff <= SDA_I;
			sda_s2_ff <= sda_s1_ff;
			sda_d3_ff <= sda_s2_ff;
		end
	end

	logic start_det, stop_det, scl_rise;
	assign start_det = scl_s2_ff && scl_d3_ff && sda_d3_ff && !sda_s2_ff;
	assign stop_det  = scl_s2_ff && scl_d3_ff && !sda_d3_ff && sda_s2_ff;
	assign scl_rise  = scl_s2_ff && !scl_d3_ff;

	// Register and engine state.
	iicl_state_type st_ff, nxt_st;
	logic [15:0]    tick_ff, nxt_tick;
	logic [1:0]     ph_ff, nxt_ph;
	logic [3:0]     rem_ff, nxt_rem;
	logic [7:0]     sh_ff, nxt_sh;
	logic [2:0]     bc_ff, nxt_bc;
	logic           mls_ff, nxt_mls;
	logic           wait_ff, nxt_wait;
	logic           rsv_ff, nxt_rsv;
	logic           master_ff, nxt_master;
	logic           csync_ff, nxt_csync;
	logic           ack_ff, nxt_ack;
	logic           busy_ff, nxt_busy;
	logic           scl_low_ff, nxt_scl_low;
	logic           sda_low_ff, nxt_sda_low;
	logic [31:0]    prdata_ff, nxt_prdata;
	logic           err_ff, nxt_err;

	logic        hit, wr, half_done, ack_phase, out_bit, idle;
	logic [9:0]  widx;
	logic [7:0]  rd_mux;
	logic [3:0]  cur;
	logic [2:0]  bc_rd;

	assign widx      = PADDR[11:2];
	assign hit       = (widx == IDX_LINE_CONTROL) || (widx == IDX_TRANSFER_MODE)
	                   || (widx == IDX_CORE_CONTROL) || (widx == IDX_CORE_DATA);
	assign wr        = PSEL && PENABLE && PWRITE && hit;
	assign idle      = (st_ff == ST_IDLE);
	assign half_done = (tick_ff == 16'(HALF_CYC - 1));
	assign ack_phase = !csync_ff && (rem_ff == 4'h1);
	assign out_bit   = mls_ff ? sh_ff[0] : sh_ff[7];
	assign bc_rd     = (rem_ff != 4'h0) ? iicl_bc_code(rem_ff, csync_ff) : bc_ff;

	// Read view of the registers.
	always_comb begin
		rd_mux = 8'h00;
		case (widx)
			IDX_LINE_CONTROL: begin
				rd_mux = {busy_ff && !csync_ff, 1'b1, !sda_low_ff, 1'b1,
				          scl_s2_ff, 1'b1, 1'b0, 1'b1};
			end
			IDX_TRANSFER_MODE: begin
				rd_mux = {mls_ff, wait_ff, rsv_ff, 1'b1, 1'b1, bc_rd};
			end
			IDX_CORE_CONTROL: begin
				rd_mux = {!idle, ack_ff, 4'h0, csync_ff, master_ff};
			end
			IDX_CORE_DATA: begin
				rd_mux = sh_ff;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_tick    = tick_ff;
		nxt_ph      = ph_ff;
		nxt_rem     = rem_ff;
		nxt_sh      = sh_ff;
		nxt_bc      = bc_ff;
		nxt_mls     = mls_ff;
		nxt_wait    = wait_ff;
		nxt_rsv     = rsv_ff;
		nxt_master  = master_ff;
		nxt_csync   = csync_ff;
		nxt_ack     = ack_ff;
		nxt_busy    = busy_ff;
		nxt_scl_low = scl_low_ff;
		nxt_sda_low = sda_low_ff;
		nxt_prdata  = prdata_ff;
		nxt_err     = err_ff;
		cur         = (rem_ff == 4'h0) ? iicl_bc_len(bc_ff, csync_ff) : rem_ff;
		// Read data is captured in the setup cycle so that no wait state is needed.
		if (PSEL && !PENABLE) begin
			nxt_prdata = {24'h000000, rd_mux};
			nxt_err    = !hit;
		end
		// Register writes.
		if (wr && widx == IDX_TRANSFER_MODE) begin
			nxt_mls  = PWDATA[TM_MLS];
			nxt_wait = PWDATA[TM_WAIT];
			nxt_rsv  = PWDATA[TM_RSV];
			if (!PWDATA[TM_COUNTER_WRITE_PROTECT]) begin
				nxt_bc = PWDATA[2:0];
			end
		end
		if (wr && widx == IDX_CORE_CONTROL) begin
			nxt_master = PWDATA[CC_MASTER];
			nxt_csync  = PWDATA[CC_CSYNC];
		end
		if (wr && widx == IDX_LINE_CONTROL && idle) begin
			if (!PWDATA[LC_DATA_OUT_WRITE_PROTECT]) begin
				nxt_sda_low = !PWDATA[LC_DATA_OUT_CONTROL];
			end
			// A repeated start is the same command issued while the bus is held.
			if (!PWDATA[LC_SCP] && master_ff && !csync_ff) begin
				nxt_st   = PWDATA[LC_BUSY] ? ST_START : ST_STOP;
				nxt_tick = 16'h0000;
				nxt_ph   = 2'h0;
			end
		end
		if (wr && widx == IDX_CORE_DATA && idle && master_ff && (csync_ff || busy_ff)) begin
			nxt_sh   = PWDATA[7:0];
			nxt_rem  = iicl_bc_len(bc_ff, csync_ff);
			nxt_st   = ST_BIT_LO;
			nxt_tick = 16'h0000;
		end
		// Bus state follows the lines in every mode.
		if (start_det) begin
			nxt_busy = 1'b1;
		end else if (stop_det) begin
			nxt_busy = 1'b0;
		end
		// Slave side counts the clock edges that another master makes.
		if (!master_ff && scl_rise && (csync_ff || busy_ff)) begin
			nxt_rem = 4'(cur - 4'h1);
			if (!(!csync_ff && cur == 4'h1)) begin
				nxt_sh = mls_ff ? {sda_s2_ff, sh_ff[7:1]} : {sh_ff[6:0], sda_s2_ff};
			end
			if (cur == 4'h1) begin
				nxt_bc = BC_ZERO;
			end
		end
		// Master engine, one step per half period of the transfer clock.
		case (st_ff)
			ST_IDLE: begin
				nxt_tick = 16'h0000;
			end
			ST_START: begin
				nxt_tick = half_done ? 16'h0000 : 16'(tick_ff + 16'h0001);
				case (ph_ff)
					2'h0: begin
						nxt_sda_low = 1'b0;
						nxt_scl_low = 1'b0;
					end
					2'h1: begin
						nxt_sda_low = 1'b1;
					end
					default: begin
						nxt_scl_low = 1'b1;
					end
				endcase
				if (half_done) begin
					nxt_ph = 2'(ph_ff + 2'h1);
					if (ph_ff == 2'h2) begin
						nxt_st = ST_IDLE;
					end
				end
			end
			ST_STOP: begin
				nxt_tick = half_done ? 16'h0000 : 16'(tick_ff + 16'h0001);
				case (ph_ff)
					2'h0: begin
						nxt_scl_low = 1'b1;
						nxt_sda_low = 1'b1;
					end
					2'h1: begin
						nxt_scl_low = 1'b0;
					end
					default: begin
						nxt_sda_low = 1'b0;
					end
				endcase
				if (half_done) begin
					nxt_ph = 2'(ph_ff + 2'h1);
					if (ph_ff == 2'h2) begin
						nxt_st = ST_IDLE;
					end
				end
			end
			ST_BIT_LO: begin
				nxt_scl_low = 1'b1;
				nxt_sda_low = ack_phase ? 1'b0 : !out_bit;
				nxt_tick    = half_done ? 16'h0000 : 16'(tick_ff + 16'h0001);
				if (half_done) begin
					nxt_st = ST_BIT_HI;
				end
			end
			ST_BIT_HI: begin
				nxt_scl_low = 1'b0;
				// The half period only runs while the line is seen high, so a slave may stretch.
				if (scl_s2_ff) begin
					nxt_tick = half_done ? 16'h0000 : 16'(tick_ff + 16'h0001);
				end
				if (scl_s2_ff && half_done) begin
					nxt_rem = 4'(rem_ff - 4'h1);
					if (ack_phase) begin
						nxt_ack = sda_s2_ff;
					end else begin
						nxt_sh = mls_ff ? {sda_s2_ff, sh_ff[7:1]} : {sh_ff[6:0], sda_s2_ff};
					end
					if (rem_ff == 4'h1) begin
						nxt_st      = ST_IDLE;
						nxt_bc      = BC_ZERO;
						nxt_scl_low = !csync_ff;
						nxt_sda_low = 1'b0;
					end else if (!csync_ff && wait_ff && rem_ff == 4'h2) begin
						nxt_st      = ST_WAIT;
						nxt_scl_low = 1'b1;
						nxt_ph      = 2'h0;
					end else begin
						nxt_st = ST_BIT_LO;
					end
				end
			end
			ST_WAIT: begin
				nxt_scl_low = 1'b1;
				nxt_tick    = half_done ? 16'h0000 : 16'(tick_ff + 16'h0001);
				if (half_done) begin
					nxt_ph = 2'(ph_ff + 2'h1);
					if (ph_ff == WAIT_LAST_HALF) begin
						nxt_st = ST_BIT_LO;
					end
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		// Start detection clears the counter last so that it wins over a write.
		if (start_det) begin
			nxt_bc = BC_ZERO;
			if (!master_ff) begin
				nxt_rem = 4'h0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			st_ff      <= ST_IDLE;
			tick_ff    <= 16'h0000;
			ph_ff      <= 2'h0;
			rem_ff     <= 4'h0;
			sh_ff      <= 8'h00;
			bc_ff      <= TM_RESET[2:0];
			mls_ff     <= TM_RESET[TM_MLS];
			wait_ff    <= TM_RESET[TM_WAIT];
			rsv_ff     <= TM_RESET[TM_RSV];
			master_ff  <= 1'b0;
			csync_ff   <= 1'b0;
			ack_ff     <= 1'b0;
			busy_ff    <= LC_RESET[LC_BUSY];
			scl_low_ff <= 1'b0;
			sda_low_ff <= !LC_RESET[LC_DATA_OUT_CONTROL];
			prdata_ff  <= 32'h00000000;
			err_ff     <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			tick_ff    <= nxt_tick;
			ph_ff      <= nxt_ph;
			rem_ff     <= nxt_rem;
			sh_ff      <= nxt_sh;
			bc_ff      <= nxt_bc;
			mls_ff     <= nxt_mls;
			wait_ff    <= nxt_wait;
			rsv_ff     <= nxt_rsv;
			master_ff  <= nxt_master;
			csync_ff   <= nxt_csync;
			ack_ff     <= nxt_ack;
			busy_ff    <= nxt_busy;
			scl_low_ff <= nxt_scl_low;
			sda_low_ff <= nxt_sda_low;
			prdata_ff  <= nxt_prdata;
			err_ff     <= nxt_err;
		end
	end

	assign PRDATA  = prdata_ff;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && err_ff;
	assign SCL_O   = 1'b0;
	assign SCL_OE  = scl_low_ff;
	assign SDA_O   = 1'b0;
	assign SDA_OE  = sda_low_ff;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	sequence s_lc_acc;
		PSEL && PENABLE && (widx == IDX_LINE_CONTROL);
	endsequence
	sequence s_lc_wr;
		s_lc_acc and PWRITE && idle;
	endsequence
	sequence s_tm_wr;
		PSEL && PENABLE && PWRITE && (widx == IDX_TRANSFER_MODE);
	endsequence

	AST_SCL_MONITOR: assert property (s_lc_acc and !PWRITE |-> PRDATA[3] == $past(scl_s2_ff))
		else $error("clock monitor does not match the line");
	AST_DATA_OUT_CONTROL_READ: assert property (s_lc_acc and !PWRITE |-> PRDATA[5] == !$past(SDA_OE))
		else $error("data output read differs from the driven level");
	AST_DATA_OUT_CONTROL_WRITE: assert property (s_lc_wr and !PWDATA[LC_DATA_OUT_WRITE_PROTECT] |=> SDA_OE == !$past(PWDATA[LC_DATA_OUT_CONTROL]))
		else $error("data output write not applied");
	AST_DATA_OUT_CONTROL_PROTECT: assert property (s_lc_wr and PWDATA[LC_DATA_OUT_WRITE_PROTECT] |=> SDA_OE == $past(SDA_OE))
		else $error("protected data output changed");
	AST_BC_PROTECT: assert property (s_tm_wr and PWDATA[TM_COUNTER_WRITE_PROTECT] && !start_det && idle && master_ff |=> $stable(bc_ff))
		else $error("protected counter changed");
	AST_START_BUSY: assert property (start_det |=> busy_ff && bc_ff == BC_ZERO)
		else $error("start not reflected in bus occupied or counter");
	AST_STOP_FREE: assert property (stop_det && !start_det |=> !busy_ff)
		else $error("stop not reflected in bus occupied");
	AST_START_GEN: assert property (s_lc_wr and master_ff && !csync_ff && !PWDATA[LC_SCP] && PWDATA[LC_BUSY] |=> st_ff == ST_START ##1 !SDA_OE && !SCL_OE)
		else $error("start command did not begin a start");
	AST_CSYNC_NO_BUSY: assert property (s_lc_wr and csync_ff |=> st_ff != ST_START && st_ff != ST_STOP)
		else $error("bus occupied acted in clock-synchronous format");
	AST_WAIT_MODE: assert property (st_ff != ST_WAIT ##1 st_ff == ST_WAIT |-> $past(master_ff && !csync_ff && wait_ff) && SCL_OE)
		else $error("wait inserted outside two-wire master mode");
	AST_BIT_ORDER: assert property (st_ff == ST_BIT_LO && $past(st_ff) == ST_BIT_LO && !ack_phase |-> SDA_OE == !(mls_ff ? sh_ff[0] : sh_ff[7]))
		else $error("data bit sent in wrong order");
endmodule : iicl_line_ctrl
`default_nettype wire

// *** test/iicl_bus_peer.sv ***
// Behavioural peer device on the two-wire bus: counts bits, acknowledges, records data.
// Assumes resolved, pulled-up wire levels and the bench system clock for sampling.
`timescale 1ns/10ps
`default_nettype none
module iicl_bus_peer (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Resolved wires and control.
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       hold_scl,
	// Pin drive.
	output var  logic       scl_oe,
	output var  logic       sda_oe,
	// Observations.
	output var  logic [7:0] rx,
	output var  int         n_rise,
	output var  int         n_st,
	output var  int         n_sp,
	output var  int         gap
);
	logic scl_q;
	logic sda_q;
	int   k;
	// The clock is held low only on request, so frames stay untouched otherwise.
	assign scl_oe = hold_scl;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			k      <= 0;
			sda_oe <= 1'b0;
			rx     <= 8'h00;
			n_rise <= 0;
			n_st   <= 0;
			n_sp   <= 0;
			gap    <= 0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda) begin
				n_st <= n_st + 1;
				k    <= 0;
			end else if (scl && scl_q && !sda_q && sda) begin
				n_sp <= n_sp + 1;
				k    <= 0;
			end else if (scl && !scl_q) begin
				n_rise <= n_rise + 1;
				k      <= k + 1;
				if (k < 8) rx <= {rx[6:0], sda};
			end else if (!scl && scl_q) begin
				if (k == 8) sda_oe <= 1'b1;
				if (k == 8) gap <= 0;
				if (k == 9) sda_oe <= 1'b0;
				if (k == 9) k <= 0;
			end else if (!scl && k == 8) begin
				gap <= gap + 1;
			end
		end
	end
endmodule : iicl_bus_peer
`default_nettype wire

// *** test/tb_iicl_line_ctrl.sv ***
// Self-checking bench for the line and mode control block over APB.
// Assumes the bus peer model and pulled-up wires resolved here.
`timescale 1ns/10ps
`default_nettype none
module tb_iicl_line_ctrl;
	import iicl_pkg::*;
	localparam int H = 4;
	localparam logic [11:0] A_LC = {IDX_LINE_CONTROL, 2'h0};
	localparam logic [11:0] A_TM = {IDX_TRANSFER_MODE, 2'h0};
	localparam logic [11:0] A_CC = {IDX_CORE_CONTROL, 2'h0};
	localparam logic [11:0] A_CD = {IDX_CORE_DATA, 2'h0};
	logic        clk_sys = 1'b0;
	logic        rst_b   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic        p_hold  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] rv;
	logic        ev;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_oe;
	logic        sda_oe;
	logic        scl_o;
	logic        sda_o;
	logic        p_scl_oe;
	logic        p_sda_oe;
	logic [7:0]  p_rx;
	int          p_rise;
	int          p_st;
	int          p_sp;
	int          p_gap;
	int          r0;
	int          mismatches = 0;
	int          n_tests    = 0;
	// Open-drain wires: anyone enabling pulls low, otherwise the pull-up wins.
	wire logic scl = !(scl_oe || p_scl_oe);
	wire logic sda = !(sda_oe || p_sda_oe);
	always #12.5 clk_sys = ~clk_sys;
	iicl_line_ctrl #(.HALF_CYC(H)) iicl_line_ctrl_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SCL_I(scl), .SCL_O(scl_o),
		.SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));
	iicl_bus_peer iicl_bus_peer_i (
		.clk(clk_sys), .rst_b(rst_b), .scl(scl), .sda(sda), .hold_scl(p_hold),
		.scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .rx(p_rx), .n_rise(p_rise),
		.n_st(p_st), .n_sp(p_sp), .gap(p_gap));
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			end_sim();
		end
		rv = prdata;
		ev = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(e, rv);
	endtask : rc
	// Polls the engine-active flag; a hung engine ends the run.
	task idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, A_CC, 8'h00);
			k++;
		end while (rv[7] !== 1'b0 && k < 500);
		if (k >= 500) begin
			mismatches++;
			end_sim();
		end
	endtask : idle
	task frame(input logic [7:0] d);
		r0 = p_rise;
		wr(A_CD, d);
		idle();
	endtask : frame
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rc(A_LC, 32'h7D);
		rc(A_TM, 32'h18);
		rc(12'h000, 32'h0);
		chk(32'h1, {31'h0, ev});
		chk(32'h0, {30'h0, scl_o, sda_o});
		p_hold <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rc(A_LC, 32'h75);
		// Nonzero counter codes are written while the clock line is low.
		wr(A_TM, 8'h0B);
		rc(A_TM, 32'h18);
		wr(A_TM, 8'h03);
		rc(A_TM, 32'h1B);
		wr(A_TM, 8'h00);
		p_hold <= 1'b0;
		repeat (6) @(posedge clk_sys);
		wr(A_LC, 8'h50);
		rc(A_LC, 32'h7D);
		wr(A_LC, 8'h40);
		repeat (6) @(posedge clk_sys);
		chk(32'h1, {31'h0, sda_oe});
		rc(A_LC, 32'hDD);
		wr(A_LC, 8'h60);
		repeat (6) @(posedge clk_sys);
		rc(A_LC, 32'h7D);
		wr(A_CC, 8'h01);
		wr(A_LC, 8'hD0);
		repeat (6) @(posedge clk_sys);
		rc(A_LC, 32'h7D);
		chk(32'h0, {31'h0, scl_oe});
		wr(A_LC, 8'h90);
		idle();
		chk(32'h3, {30'h0, scl_oe, sda_oe});
		rc(A_LC, 32'hD5);
		frame(8'hA5);
		chk(32'hA5, {24'h0, p_rx});
		chk(32'h9, 32'(p_rise - r0));
		chk(32'h0, {31'h0, p_gap > 4 * H});
		rc(A_CC, 32'h01);
		rc(A_TM, 32'h18);
		wr(A_TM, 8'hC8);
		rc(A_TM, 32'hD8);
		frame(8'h35);
		chk(32'hAC, {24'h0, p_rx});
		chk(32'h1, {31'h0, p_gap > 4 * H});
		rc(A_CC, 32'h01);
		r0 = p_st;
		wr(A_LC, 8'h90);
		idle();
		chk(32'h1, 32'(p_st - r0));
		wr(A_TM, 8'h03);
		rc(A_TM, 32'h1B);
		frame(8'hF0);
		chk(32'h4, 32'(p_rise - r0));
		rc(A_CC, 32'h41);
		rc(A_TM, 32'h18);
		r0 = p_sp;
		wr(A_LC, 8'h10);
		idle();
		chk(32'h1, 32'(p_sp - r0));
		rc(A_LC, 32'h7D);
		wr(A_CC, 8'h03);
		wr(A_LC, 8'h90);
		repeat (20) @(posedge clk_sys);
		rc(A_LC, 32'h7D);
		chk(32'h0, {30'h0, scl_oe, sda_oe});
		rc(A_TM, 32'h18);
		frame(8'h5A);
		chk(32'h8, 32'(p_rise - r0));
		chk(32'h5A, {24'h0, p_rx});
		rc(A_TM, 32'h18);
		end_sim();
	end
endmodule : tb_iicl_line_ctrl
`default_nettype wire
